// ==== verilog/windowed_watchdog_regs.v ====
// register file and counter of the windowed watchdog, on a classic wishbone slave
`timescale 1ns/1ps
`include "windowed_watchdog_defines.vh"

module windowed_watchdog_regs (
    input  wire        clk_i,                 // system clock, 40 MHz
    input  wire        rst_i,                 // synchronous reset, active high
    input  wire [11:0] adr_i,                 // wishbone byte address
    input  wire [7:0]  dat_i,                 // wishbone write data
    output reg  [7:0]  dat_o,                 // wishbone read data
    input  wire        we_i,                  // wishbone write enable
    input  wire        sel_i,                 // wishbone byte select
    input  wire        cyc_i,                 // wishbone cycle
    input  wire        stb_i,                 // wishbone strobe
    output reg         ack_o,                 // wishbone acknowledge
    input  wire [2:0]  clock_source_fuse_i,   // clock source configuration fuse
    input  wire [2:0]  window_size_fuse_i,    // window configuration fuse
    input  wire [4:0]  prescale_fuse_i,       // time-out prescale configuration fuse
    input  wire        watchdog_active_i,     // watchdog enabled by the mode logic
    input  wire        windowed_mode_i,       // windowed clearing in force
    input  wire        tick_i,                // one pulse per tick of the selected clock
    input  wire        clear_watchdog_i,      // clear instruction executed, one pulse
    output wire [2:0]  clock_source_o,        // selected watchdog clock source
    output wire [4:0]  timeout_prescale_o,    // time-out prescale setting
    output wire        software_enable_o,     // software watchdog enable
    output reg         reset_request_o,       // one-cycle reset request
    output wire        irq_o                  // level interrupt
);

    reg  [4:0]  timeout_prescale_reg;
    reg         software_enable_reg;
    reg  [2:0]  clock_source_reg;
    reg  [2:0]  window_reg;
    reg  [17:0] prescale_count_reg;
    reg  [4:0]  window_counter_reg;
    reg         armed_reg;
    reg  [`IRQ_WIDTH-1:0] irq_status_reg;
    reg  [`IRQ_WIDTH-1:0] irq_mask_reg;
    reg  [`IRQ_WIDTH-1:0] irq_event;
    reg  [7:0]  read_data_next;
    reg  [17:0] prescale_count_next;
    reg  [4:0]  window_counter_next;
    reg         armed_next;

    wire        bus_req;
    wire        wr_strobe;
    wire        rd_strobe;
    wire        cs_writable;
    wire        window_writable;
    wire        prescale_writable;
    wire [2:0]  window_effective;
    wire        window_open;
    wire        control_write;
    wire        violation;
    wire        timeout;
    wire [4:0]  prescale_reset_value;
    wire [22:0] full_count;

    assign bus_req   = cyc_i & stb_i & ~ack_o;
    assign wr_strobe = bus_req & we_i & sel_i;
    assign rd_strobe = bus_req & ~we_i;

    assign cs_writable       = (clock_source_fuse_i == `FUSE_SOFTWARE_CTRL);
    assign window_writable   = (window_size_fuse_i == `FUSE_SOFTWARE_CTRL);
    assign prescale_writable = (prescale_fuse_i == `CPS_SOFTWARE_CTRL);
    assign prescale_reset_value = prescale_writable ? `PS_RESET_DEFAULT : prescale_fuse_i;

    // fuse value overrides the field unless the fuse hands control to software
    assign window_effective = window_writable ? window_reg : window_size_fuse_i;

    assign clock_source_o     = clock_source_reg;
    assign timeout_prescale_o = timeout_prescale_reg;
    assign software_enable_o  = software_enable_reg;

    windowed_watchdog_window_check window_check (
        .window_code_i    (window_effective),
        .window_counter_i (window_counter_reg),
        .window_open_o    (window_open)
    );

    assign control_write = wr_strobe &&
                           ((adr_i == `ADDR_PRESCALE_AND_ENABLE) ||
                            (adr_i == `ADDR_CLOCK_AND_WINDOW));

    // clearing unarmed, or while the window is closed, is a violation
    assign violation = watchdog_active_i & windowed_mode_i & clear_watchdog_i &
                       (~armed_reg | ~window_open);

    // time-out when the combined window counter and prescale count reaches the end of the selected interval
    assign full_count = {window_counter_reg, prescale_count_reg};
    assign timeout    = watchdog_active_i & tick_i &
                        (full_count == timeout_mask(timeout_prescale_reg));

    // count value at which the selected interval ends, 1:32 at code 0
    function [22:0] timeout_mask;
        input [4:0] ps;
        reg   [4:0] sel;
        begin
            sel = (ps > 5'h12) ? 5'h00 : ps;
            timeout_mask = (23'h00001F << sel) | 23'h00001F;
        end
    endfunction

    always @*
    begin
        prescale_count_next = prescale_count_reg;
        window_counter_next = window_counter_reg;
        armed_next          = armed_reg;
        if (rd_strobe && (adr_i == `ADDR_PRESCALE_AND_ENABLE))
            armed_next = 1'b1;
        if (control_write || clear_watchdog_i || !watchdog_active_i || timeout)
        begin
            prescale_count_next = 18'h00000;
            window_counter_next = 5'h00;
            armed_next          = 1'b0;
        end
        else if (tick_i)
        begin
            {window_counter_next, prescale_count_next} = full_count + 23'h000001;
        end
    end

    always @*
    begin
        irq_event = {`IRQ_WIDTH{1'b0}};
        irq_event[`IRQ_VIOLATION_BIT] = violation;
        irq_event[`IRQ_TIMEOUT_BIT]   = timeout;
    end

    always @*
    begin
        read_data_next = 8'h00;
        if (adr_i == `ADDR_PRESCALE_AND_ENABLE)
            read_data_next = {2'b00, timeout_prescale_reg, software_enable_reg};
        else if (adr_i == `ADDR_CLOCK_AND_WINDOW)
            read_data_next = {1'b0, clock_source_reg, 1'b0, window_reg};
        else if (adr_i == `ADDR_PRESCALE_COUNT_LOW)
            read_data_next = prescale_count_reg[7:0];
        else if (adr_i == `ADDR_PRESCALE_COUNT_HIGH)
            read_data_next = prescale_count_reg[15:8];
        else if (adr_i == `ADDR_WINDOW_COUNTER_STATUS)
            read_data_next = {window_counter_reg, armed_reg,
                              prescale_count_reg[17:16]};
        else if (adr_i == `ADDR_IRQ_STATUS)
            read_data_next = {6'h00, irq_status_reg};
        else if (adr_i == `ADDR_IRQ_MASK)
            read_data_next = {6'h00, irq_mask_reg};
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 8'h00;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= rd_strobe ? read_data_next : 8'h00;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timeout_prescale_reg <= prescale_reset_value;
            software_enable_reg  <= 1'b0;
            clock_source_reg     <= cs_writable ? `CS_RESET : clock_source_fuse_i;
            window_reg           <= window_size_fuse_i;
        end
        else if (wr_strobe && (adr_i == `ADDR_PRESCALE_AND_ENABLE))
        begin
            if (prescale_writable)
                timeout_prescale_reg <= dat_i[5:1];
            software_enable_reg <= dat_i[0];
        end
        else if (wr_strobe && (adr_i == `ADDR_CLOCK_AND_WINDOW))
        begin
            if (cs_writable)
                clock_source_reg <= dat_i[`CS_MSB:`CS_LSB];
            if (window_writable)
                window_reg <= dat_i[`WINDOW_MSB:`WINDOW_LSB];
        end
    end

    // counters and status take no bus write data; control register writes clear them and a read of the first control register arms
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prescale_count_reg <= 18'h00000;
            window_counter_reg <= 5'h00;
            armed_reg          <= 1'b0;
            reset_request_o    <= 1'b0;
        end
        else
        begin
            prescale_count_reg <= prescale_count_next;
            window_counter_reg <= window_counter_next;
            armed_reg          <= armed_next;
            reset_request_o    <= violation | timeout;
        end
    end

    // set wins over a write-one-to-clear in the same cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status_reg <= {`IRQ_WIDTH{1'b0}};
            irq_mask_reg   <= {`IRQ_WIDTH{1'b0}};
        end
        else
        begin
            if (wr_strobe && (adr_i == `ADDR_IRQ_STATUS))
                irq_status_reg <= (irq_status_reg & ~dat_i[`IRQ_WIDTH-1:0]) | irq_event;
            else
                irq_status_reg <= irq_status_reg | irq_event;
            if (wr_strobe && (adr_i == `ADDR_IRQ_MASK))
                irq_mask_reg <= dat_i[`IRQ_WIDTH-1:0];
        end
    end

    assign irq_o = |(irq_status_reg & irq_mask_reg);

endmodule

// ==== verilog/windowed_watchdog_defines.vh ====
// register offsets, field positions, reset values and codes for the windowed watchdog registers
`ifndef WINDOWED_WATCHDOG_DEFINES_VH
`define WINDOWED_WATCHDOG_DEFINES_VH

`define ADDR_PRESCALE_AND_ENABLE   12'h078
`define ADDR_CLOCK_AND_WINDOW      12'h079
`define ADDR_PRESCALE_COUNT_LOW    12'h07A
`define ADDR_PRESCALE_COUNT_HIGH   12'h07B
`define ADDR_WINDOW_COUNTER_STATUS 12'h07C
`define ADDR_IRQ_STATUS            12'h07D
`define ADDR_IRQ_MASK              12'h07E

`define CS_LSB                     4
`define CS_MSB                     6
`define WINDOW_LSB                 0
`define WINDOW_MSB                 2
`define STATUS_ARMED_BIT           2

`define FUSE_SOFTWARE_CTRL         3'h7
`define CS_RESET                   3'h0
`define CS_LOW_FREQ_INTERNAL_OSC   3'h0
`define CS_MID_FREQ_INTERNAL_OSC   3'h1
`define CS_SECONDARY_OSC           3'h2
`define CS_EXTERNAL_OSC            3'h3
`define WINDOW_FULL_OPEN           3'h7
`define PS_RESET_DEFAULT           5'h0B
`define CPS_SOFTWARE_CTRL          5'h1F

`define IRQ_VIOLATION_BIT          0
`define IRQ_TIMEOUT_BIT            1
`define IRQ_WIDTH                  2

`endif

// ==== verilog/windowed_watchdog_window_check.v ====
// window-open decoder comparing the window counter against the selected window code
`timescale 1ns/1ps
`include "windowed_watchdog_defines.vh"

module windowed_watchdog_window_check (
    input  wire [2:0] window_code_i,   // effective window size code
    input  wire [4:0] window_counter_i, // current 5-bit window counter
    output wire       window_open_o     // high while clearing is allowed
);

    // threshold is four steps of the counter per eighth of the period
    function [4:0] open_threshold;
        input [2:0] code;
        begin
            open_threshold = {(`WINDOW_FULL_OPEN - code), 2'b00};
        end
    endfunction

    assign window_open_o = (window_counter_i >= open_threshold(window_code_i));

endmodule

// ==== verification/windowed_watchdog_regs_properties.sv ====
// assertion checker for the windowed watchdog register block
`timescale 1ns/1ps
module windowed_watchdog_checker (
    input wire logic        clk_i, rst_i, we_i, sel_i, cyc_i, stb_i, ack_o,
    input wire logic [11:0] adr_i,
    input wire logic [7:0]  dat_o,
    input wire logic [2:0]  clock_source_fuse_i, clock_source_o,
    input wire logic        windowed_mode_i, watchdog_active_i, clear_watchdog_i, reset_request_o
);
    logic armed_q;
    wire  take = cyc_i && stb_i && !ack_o;
    // mirror of the armed state, set by a read of the first control register
    always @(posedge clk_i)
        if (rst_i || !watchdog_active_i || clear_watchdog_i)
            armed_q <= 1'b0;
        else if (take && adr_i == 12'h078 && !we_i)
            armed_q <= 1'b1;
        else if (take && we_i && sel_i && adr_i[11:1] == 11'h03C)
            armed_q <= 1'b0;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_follows; take |=> ack_o; endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_unmapped; ack_o && !$past(we_i) && ($past(adr_i) < 12'h078 ||
        $past(adr_i) > 12'h07E) |-> dat_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_armed_bit; ack_o && !$past(we_i) && $past(adr_i) == 12'h07C
        |-> dat_o[2] == $past(armed_q); endproperty
    a_armed_bit: assert property (p_armed_bit) else $error("armed bit wrong");
    property p_cs_reset; $fell(rst_i) && clock_source_fuse_i == 3'h7 |-> clock_source_o == 3'h0;
    endproperty
    a_cs_reset: assert property (p_cs_reset) else $error("clock source reset wrong");
    property p_cs_fixed; clock_source_fuse_i != 3'h7 |-> clock_source_o == clock_source_fuse_i;
    endproperty
    a_cs_fixed: assert property (p_cs_fixed) else $error("clock source not fixed");
    property p_unarmed; windowed_mode_i && watchdog_active_i && clear_watchdog_i && !armed_q
        |-> ##[1:2] reset_request_o; endproperty
    a_unarmed: assert property (p_unarmed) else $error("no violation reset");
    property p_req_pulse; reset_request_o |=> !reset_request_o; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
    c_arm: cover property (take && adr_i == 12'h078 && !we_i);
    c_viol: cover property (reset_request_o);
    c_fixed: cover property (clock_source_fuse_i != 3'h7 && take && we_i);
endmodule
bind windowed_watchdog_regs windowed_watchdog_checker i_windowed_watchdog_checker (.clk_i(clk_i), .rst_i(rst_i),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .adr_i(adr_i),
    .dat_o(dat_o), .clock_source_fuse_i(clock_source_fuse_i), .clock_source_o(clock_source_o),
    .windowed_mode_i(windowed_mode_i), .watchdog_active_i(watchdog_active_i),
    .clear_watchdog_i(clear_watchdog_i), .reset_request_o(reset_request_o));

// ==== verification/windowed_watchdog_regs_test.sv ====
// self-checking bench for the windowed watchdog register block
`timescale 1ns/1ps
module windowed_watchdog_regs_test;
    logic        clk_i = 0, rst_i = 1, we_i = 0, sel_i = 0, cyc_i = 0, stb_i = 0;
    logic [11:0] adr_i = 0;
    logic [7:0]  dat_i = 0, rd;
    logic [2:0]  cs_fuse = 3'h7, ws_fuse = 3'h7;
    logic        act = 0, wmode = 0, tick = 0, clr = 0;
    logic [7:0]  rr_cnt = 0;
    int          mismatches = 0, n_checks = 0;
    wire [7:0]   dat_o;
    wire [2:0]   cs_o;
    wire [4:0]   tps_o;
    wire         ack_o, rr, irq_o, sen_o;
    always #12.5 clk_i = ~clk_i;
    // reset requests are counted by this process alone
    always @(posedge clk_i) if (rr) rr_cnt <= rr_cnt + 8'h01;
    windowed_watchdog_regs i_windowed_watchdog_regs (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .clock_source_fuse_i(cs_fuse),
        .window_size_fuse_i(ws_fuse), .prescale_fuse_i(5'h1F), .watchdog_active_i(act),
        .windowed_mode_i(wmode), .tick_i(tick), .clear_watchdog_i(clr),
        .clock_source_o(cs_o), .timeout_prescale_o(tps_o), .software_enable_o(sen_o),
        .reset_request_o(rr), .irq_o(irq_o));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one classic cycle; the leading edge leaves an idle cycle after the last one
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, sel_i, we_i, adr_i, dat_i} <= {3'b111, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        rd = dat_o;
        {cyc_i, stb_i, we_i, sel_i} <= 4'h0;
        if (n >= 20)
        begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic clear_pulse;
        @(posedge clk_i) clr <= 1'b1;
        @(posedge clk_i) clr <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic do_reset(input logic [2:0] c, input logic [2:0] w);
        @(posedge clk_i) {rst_i, cs_fuse, ws_fuse} <= {1'b1, c, w};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    initial
    begin
        #(25 * 20000);
        mismatches++;
        test_done();
    end
    initial
    begin
        do_reset(3'h7, 3'h7);
        rchk(12'h079, 8'h07);
        rchk(12'h07A, 8'h00);
        rchk(12'h07B, 8'h00);
        rchk(12'h07C, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wb(1'b1, 12'h079, {1'b0, c[2:0], 4'h7});
            chk({5'h00, cs_o}, c[7:0]);
        end
        wb(1'b1, 12'h079, 8'h35);
        rchk(12'h079, 8'h35);
        wb(1'b1, 12'h07A, 8'hFF);
        rchk(12'h07A, 8'h00);
        wb(1'b1, 12'h07C, 8'hFF);
        rchk(12'h07C, 8'h00);
        rchk(12'h080, 8'h00);
        {act, wmode} <= 2'b11;
        wb(1'b1, 12'h079, 8'h07);
        repeat (3) @(posedge clk_i) tick <= ~tick;
        @(posedge clk_i) tick <= 1'b0;
        rchk(12'h07A, 8'h02);
        rchk(12'h07B, 8'h00);
        rchk(12'h078, 8'h16);
        rchk(12'h07C, 8'h04);
        wb(1'b1, 12'h078, 8'h17);
        chk({3'h0, tps_o}, 8'h0B);
        chk({7'h00, sen_o}, 8'h01);
        rchk(12'h07A, 8'h00);
        rchk(12'h07C, 8'h00);
        wb(1'b0, 12'h078, 8'h00);
        clear_pulse();
        chk(rr_cnt, 8'h00);
        wb(1'b1, 12'h079, 8'h06);
        wb(1'b0, 12'h078, 8'h00);
        clear_pulse();
        chk(rr_cnt, 8'h01);
        wb(1'b1, 12'h079, 8'h07);
        clear_pulse();
        chk(rr_cnt, 8'h02);
        chk(irq_o, 8'h00);
        rchk(12'h07D, 8'h01);
        wb(1'b1, 12'h07E, 8'h01);
        chk(irq_o, 8'h01);
        wb(1'b1, 12'h07D, 8'h01);
        chk(irq_o, 8'h00);
        do_reset(3'h2, 3'h3);
        rchk(12'h079, 8'h23);
        wb(1'b1, 12'h079, 8'h77);
        rchk(12'h079, 8'h23);
        chk({5'h00, cs_o}, 8'h02);
        test_done();
    end
endmodule
